// ---- design/irs_pkg.sv ----
// Constants and types for the reference input selection configuration block
package irs_pkg;
	// Register offsets
	localparam logic [7:0] OFF_PHASE_OFS  = 8'h1D;
	localparam logic [7:0] OFF_PUMP_CUR   = 8'h1E;
	localparam logic [7:0] OFF_MON_MODE   = 8'h20;
	localparam logic [7:0] OFF_SEL_CTRL   = 8'h21;
	localparam logic [7:0] OFF_HOLDOFF    = 8'h22;
	localparam logic [7:0] OFF_HO_RANGES  = 8'h23;
	localparam logic [7:0] OFF_STATUS     = 8'h24;

	// Field positions
	localparam int POS_OFS_EN    = 5;
	localparam int POS_RATIO_LO  = 3;
	localparam int POS_BLOCK     = 2;
	localparam int POS_HO_CTRL_N = 1;
	localparam int POS_SRC_INT   = 0;
	localparam int POS_REVERTIVE_SWITCH_ON      = 4;
	localparam int POS_MODE_LO   = 2;
	localparam int POS_INT_SEL   = 0;
	localparam int POS_PRESCALE  = 6;

	// Reset values
	localparam logic [4:0] RST_OFS_CODE  = 5'h00;
	localparam logic [4:0] RST_PUMP_CODE = 5'h06;
	localparam logic [4:0] RST_RATIO     = 5'h00;
	localparam logic [7:0] RST_HOLDOFF   = 8'h80;
	localparam logic [1:0] RST_MODE      = 2'b00;

	// Scaling: tenths of a degree per offset step, microamps per pump step
	localparam logic [8:0]  OFS_STEP_DDEG = 9'h009;
	localparam logic [12:0] PUMP_STEP_UA  = 13'h00C8;

	// Activity monitor defaults
	localparam int MON_WINDOW = 16;
	localparam int MON_TOL    = 2;

	// Selection mode field codes
	typedef enum logic [1:0] {
		MODE_MANUAL      = 2'b00,
		MODE_AUTO        = 2'b01,
		MODE_SHORT_HOLD  = 2'b10,
		MODE_AUTO_HOLD   = 2'b11
	} irs_mode_e;

	// Holdover state
	typedef enum logic [1:0] {
		HS_RUN  = 2'b00,
		HS_HOLD = 2'b01
	} irs_hold_e;
endpackage

// ---- design/irs_mon_if.sv ----
// Carrier between the control block and the activity monitor
`timescale 1ns/1ps
interface irs_mon_if;
	logic [5:0] ratio;
	logic       osc_tick;
	logic       ref_tick;
	logic       active;
	modport ctrl (output ratio, output osc_tick, output ref_tick,
		input active);
	modport mon (input ratio, input osc_tick, input ref_tick,
		output active);
endinterface

// ---- design/irs_activity_mon.sv ----
// Input activity monitor: ref edges against divided oscillator ticks
`timescale 1ns/1ps
module irs_activity_mon #(
	parameter int WINDOW = irs_pkg::MON_WINDOW,
	parameter int TOL    = irs_pkg::MON_TOL
) (
	input  wire logic i_mclk,
	input  wire logic i_sys_rst,
	irs_mon_if.mon    mon
);
	typedef struct packed {
		logic [5:0] div_cnt;
		logic [7:0] win_cnt;
		logic [7:0] ref_cnt;
		logic       active;
	} irs_mon_s;

	irs_mon_s st_q;
	irs_mon_s st_d;

	// Divide oscillator ticks, count ref edges per window
	always_comb begin
		logic div_tick;
		div_tick = 1'b0;
		st_d = st_q;
		if (mon.ref_tick && st_q.ref_cnt != 8'hFF) begin
			st_d.ref_cnt = st_q.ref_cnt + 8'h01;
		end
		if (mon.osc_tick) begin
			if (st_q.div_cnt + 6'h01 >= mon.ratio) begin
				st_d.div_cnt = 6'h00;
				div_tick = 1'b1;
			end else begin
				st_d.div_cnt = st_q.div_cnt + 6'h01;
			end
		end
		if (div_tick) begin
			if (st_q.win_cnt == 8'(WINDOW - 1)) begin
				st_d.win_cnt = 8'h00;
				// Judge the finished window, this cycle's edge included
				st_d.active = (st_d.ref_cnt >= 8'(WINDOW - TOL)) &&
					(st_d.ref_cnt <= 8'(WINDOW + TOL));
				st_d.ref_cnt = 8'h00;
			end else begin
				st_d.win_cnt = st_q.win_cnt + 8'h01;
			end
		end
	end

	// State register
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign mon.active = st_q.active;
endmodule

// ---- design/irs_input_ref_select_config.sv ----
// Reference input selection, phase offset and pump current configuration
// Functional notes
// - Offset enable set applies 5-bit offset to detector; clear applies none.
// - Offset scales 0.9 degrees per code step, 27.9 degrees at top.
// - Second pump current is 200 uA times code plus one.
// - Monitor compares selected input with oscillator divided by ratio.
// - Blocking bit clear passes both inputs; set gates off inactive one.
// - Holdover control low enters holdover on manual switch; mode ignored.
// - Holdover control high (reset value) lets mode field govern switching.
// - Manual choice from pin when source bit zero, register bit when one.
// - Mode 00 manual, 01 auto, 10 short holdover, 11 auto holdover.
// - Internal select bit zero picks input A, one picks input B.
`timescale 1ns/1ps
module irs_input_ref_select_config #(
	parameter int MON_WINDOW = irs_pkg::MON_WINDOW,
	parameter int MON_TOL    = irs_pkg::MON_TOL
) (
	input  wire logic        i_mclk,
	input  wire logic        i_sys_rst,
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic [7:0]  i_reg_wdata,
	input  wire logic        i_reg_rd,
	input  wire logic        i_external_ref_choice_pin,
	input  wire logic        i_auto_choice,
	input  wire logic        i_ref_input_a,
	input  wire logic        i_ref_input_b,
	input  wire logic        i_osc_tick,
	output logic [7:0]       o_reg_rdata,
	output logic             o_phase_offset_enable,
	output logic [4:0]       o_phase_offset_code,
	output logic [8:0]       o_phase_offset_ddeg,
	output logic [4:0]       o_second_pump_current_code,
	output logic [12:0]      o_second_pump_current_ua,
	output logic [5:0]       o_monitor_ratio,
	output logic             o_ref_input_a_gated,
	output logic             o_ref_input_b_gated,
	output logic             o_active_ref,
	output logic [1:0]       o_selection_mode_field,
	output logic             o_holdover,
	output logic             o_manual_mode,
	output logic [7:0]       o_holdoff_period,
	output logic [1:0]       o_holdoff_prescale,
	output logic [1:0]       o_validation_count
);
	typedef struct packed {
		logic                phase_offset_enable;
		logic [4:0]          phase_offset_code;
		logic [4:0]          second_pump_current_code;
		logic [4:0]          monitor_ratio_code;
		logic                block_inactive;
		logic                manual_holdover_ctrl_n;
		logic                src_internal;
		logic                revertive_switch_on;
		logic [1:0]          selection_mode_field;
		logic                int_sel;
		logic [7:0]          holdoff_period;
		logic [1:0]          holdoff_prescale;
		logic [1:0]          validation_count;
		logic [7:0]          rdata;
		logic [8:0]          ofs_ddeg;
		logic [12:0]         pump_ua;
		logic [5:0]          ratio;
		logic                a_gated;
		logic                b_gated;
		logic                active_ref;
		logic                manual_prev;
		irs_pkg::irs_hold_e  hold_state;
		logic                manual_mode;
		logic                holdover;
	} irs_cfg_s;

	irs_cfg_s st_q;
	irs_cfg_s st_d;

	irs_mon_if mon_bus ();

	// Activity monitor on the active input
	irs_activity_mon #(
		.WINDOW (MON_WINDOW),
		.TOL    (MON_TOL)
	) u_mon (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.mon       (mon_bus.mon)
	);

	// Monitor watches the raw input, so blocking never starves it
	assign mon_bus.ratio    = st_q.ratio;
	assign mon_bus.osc_tick = i_osc_tick;
	assign mon_bus.ref_tick = st_q.active_ref ? i_ref_input_b : i_ref_input_a;

	// Monitor ratio code to divide value
	function automatic logic [5:0] ratio_decode(input logic [4:0] code);
		logic [5:0] r;
		r = 6'h01;
		if (!code[4]) begin
			unique case (code[1:0])
				2'b00: r = 6'h01;
				2'b01: r = 6'h04;
				2'b10: r = 6'h10;
				2'b11: r = 6'h08;
			endcase
		end else if (code[3] || code[2]) begin
			r = 6'h20;
		end else begin
			unique case (code[1:0])
				2'b00: r = 6'h02;
				2'b01: r = 6'h05;
				2'b10: r = 6'h0C;
				2'b11: r = 6'h18;
			endcase
		end
		return r;
	endfunction

	// Register writes, derived values and selection logic
	always_comb begin
		logic manual_choice;
		logic is_manual;
		logic [7:0] rd;
		logic manual_switch;
		manual_choice = 1'b0;
		manual_switch = 1'b0;
		is_manual = 1'b0;
		rd = 8'h00;
		st_d = st_q;

		// Writes keep only defined fields
		if (i_reg_wr) begin
			unique case (i_reg_addr)
				irs_pkg::OFF_PHASE_OFS: begin
					st_d.phase_offset_enable =
						i_reg_wdata[irs_pkg::POS_OFS_EN];
					st_d.phase_offset_code = i_reg_wdata[4:0];
				end
				irs_pkg::OFF_PUMP_CUR: begin
					st_d.second_pump_current_code = i_reg_wdata[4:0];
				end
				irs_pkg::OFF_MON_MODE: begin
					st_d.monitor_ratio_code =
						i_reg_wdata[irs_pkg::POS_RATIO_LO +: 5];
					st_d.block_inactive = i_reg_wdata[irs_pkg::POS_BLOCK];
					st_d.manual_holdover_ctrl_n =
						i_reg_wdata[irs_pkg::POS_HO_CTRL_N];
					st_d.src_internal = i_reg_wdata[irs_pkg::POS_SRC_INT];
				end
				irs_pkg::OFF_SEL_CTRL: begin
					st_d.revertive_switch_on = i_reg_wdata[irs_pkg::POS_REVERTIVE_SWITCH_ON];
					st_d.selection_mode_field =
						i_reg_wdata[irs_pkg::POS_MODE_LO +: 2];
					st_d.int_sel = i_reg_wdata[irs_pkg::POS_INT_SEL];
				end
				irs_pkg::OFF_HOLDOFF: begin
					st_d.holdoff_period = i_reg_wdata;
				end
				irs_pkg::OFF_HO_RANGES: begin
					st_d.holdoff_prescale =
						i_reg_wdata[irs_pkg::POS_PRESCALE +: 2];
					st_d.validation_count = i_reg_wdata[1:0];
				end
				default: begin
				end
			endcase
		end

		// Offset applied only when enabled
		st_d.ofs_ddeg = st_d.phase_offset_enable ?
			9'(st_d.phase_offset_code * irs_pkg::OFS_STEP_DDEG) :
			9'h000;
		st_d.pump_ua = 13'(({8'h00, st_d.second_pump_current_code} +
			13'h0001) * irs_pkg::PUMP_STEP_UA);
		st_d.ratio = ratio_decode(st_d.monitor_ratio_code);

		// Manual choice source: pin or register bit
		manual_choice = st_q.src_internal ? st_q.int_sel :
			i_external_ref_choice_pin;
		// Control low forces manual; otherwise mode bit 0 decides
		is_manual = !st_q.manual_holdover_ctrl_n ||
			(st_q.selection_mode_field == irs_pkg::MODE_MANUAL) ||
			(st_q.selection_mode_field == irs_pkg::MODE_SHORT_HOLD);
		st_d.manual_mode = is_manual;
		st_d.active_ref = is_manual ? manual_choice : i_auto_choice;
		st_d.manual_prev = manual_choice;
		// A change of manual choice under low control is the trigger
		manual_switch = !st_q.manual_holdover_ctrl_n &&
			(manual_choice != st_q.manual_prev);

		// Holdover: entered on manual switch under low control, left on high control or monitor activity
		unique case (st_q.hold_state)
			irs_pkg::HS_RUN: begin
				if (manual_switch) begin
					st_d.hold_state = irs_pkg::HS_HOLD;
				end
			end
			irs_pkg::HS_HOLD: begin
				// A fresh switch beats the monitor's release
				if (st_q.manual_holdover_ctrl_n ||
					(mon_bus.active && !manual_switch)) begin
					st_d.hold_state = irs_pkg::HS_RUN;
				end
			end
			default: st_d.hold_state = irs_pkg::HS_RUN;
		endcase
		// Registered copy keeps the holdover output on a flop
		st_d.holdover = (st_d.hold_state == irs_pkg::HS_HOLD);

		// Gate off the inactive input when blocking
		st_d.a_gated = i_ref_input_a &
			(!st_q.block_inactive || !st_d.active_ref);
		st_d.b_gated = i_ref_input_b &
			(!st_q.block_inactive || st_d.active_ref);

		// Read mux, reserved bits zero
		unique case (i_reg_addr)
			irs_pkg::OFF_PHASE_OFS:
				rd = {2'b00, st_q.phase_offset_enable, st_q.phase_offset_code};
			irs_pkg::OFF_PUMP_CUR:
				rd = {3'b000, st_q.second_pump_current_code};
			irs_pkg::OFF_MON_MODE:
				rd = {st_q.monitor_ratio_code, st_q.block_inactive,
					st_q.manual_holdover_ctrl_n, st_q.src_internal};
			irs_pkg::OFF_SEL_CTRL:
				rd = {3'b000, st_q.revertive_switch_on,
					st_q.selection_mode_field, 1'b0, st_q.int_sel};
			irs_pkg::OFF_HOLDOFF:
				rd = st_q.holdoff_period;
			irs_pkg::OFF_HO_RANGES:
				rd = {st_q.holdoff_prescale, 4'h0, st_q.validation_count};
			irs_pkg::OFF_STATUS:
				rd = {5'h00, st_q.holdover,
					mon_bus.active, st_q.active_ref};
			default:
				rd = 8'h00;
		endcase
		if (i_reg_rd) begin
			st_d.rdata = rd;
		end
	end

	// State register with power-on defaults
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			st_q <= '0;
			st_q.phase_offset_code <= irs_pkg::RST_OFS_CODE;
			st_q.second_pump_current_code <= irs_pkg::RST_PUMP_CODE;
			st_q.monitor_ratio_code <= irs_pkg::RST_RATIO;
			st_q.manual_holdover_ctrl_n <= 1'b1;
			st_q.selection_mode_field <= irs_pkg::RST_MODE;
			st_q.holdoff_period <= irs_pkg::RST_HOLDOFF;
			st_q.pump_ua <= 13'(({8'h00, irs_pkg::RST_PUMP_CODE} +
				13'h0001) * irs_pkg::PUMP_STEP_UA);
			st_q.ratio <= 6'h01;
			st_q.manual_mode <= 1'b1;
			st_q.hold_state <= irs_pkg::HS_RUN;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state register
	assign o_reg_rdata = st_q.rdata;
	assign o_phase_offset_enable = st_q.phase_offset_enable;
	assign o_phase_offset_code = st_q.phase_offset_code;
	assign o_phase_offset_ddeg = st_q.ofs_ddeg;
	assign o_second_pump_current_code = st_q.second_pump_current_code;
	assign o_second_pump_current_ua = st_q.pump_ua;
	assign o_monitor_ratio = st_q.ratio;
	assign o_ref_input_a_gated = st_q.a_gated;
	assign o_ref_input_b_gated = st_q.b_gated;
	assign o_active_ref = st_q.active_ref;
	assign o_selection_mode_field = st_q.selection_mode_field;
	assign o_holdover = st_q.holdover;
	assign o_manual_mode = st_q.manual_mode;
	assign o_holdoff_period = st_q.holdoff_period;
	assign o_holdoff_prescale = st_q.holdoff_prescale;
	assign o_validation_count = st_q.validation_count;
endmodule

// ---- bench/irs_chk.sv ----
// Port assertions for the reference selection configuration block
`timescale 1ns/1ps
module irs_chk (
	input wire logic        i_mclk,
	input wire logic        i_sys_rst,
	input wire logic [7:0]  i_reg_addr,
	input wire logic        i_reg_wr,
	input wire logic [7:0]  i_reg_wdata,
	input wire logic        i_reg_rd,
	input wire logic        i_external_ref_choice_pin,
	input wire logic        i_ref_input_a,
	input wire logic [7:0]  o_reg_rdata,
	input wire logic        o_phase_offset_enable,
	input wire logic [4:0]  o_phase_offset_code,
	input wire logic [8:0]  o_phase_offset_ddeg,
	input wire logic [4:0]  o_second_pump_current_code,
	input wire logic [12:0] o_second_pump_current_ua,
	input wire logic        o_ref_input_a_gated,
	input wire logic        o_active_ref,
	input wire logic [1:0]  o_selection_mode_field,
	input wire logic        o_holdover,
	input wire logic        o_manual_mode
);
	logic [1:0] ctl_q;
	logic       sel_q;
	logic [7:0] wd_q;
	logic [7:0] ofs_q;
	// Shadow of control bits and last write data
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			ctl_q <= 2'b10;
			sel_q <= 1'b0;
			wd_q  <= 8'h00;
			ofs_q <= 8'h00;
		end else begin
			wd_q  <= i_reg_wdata;
			ofs_q <= {2'b00, o_phase_offset_enable, o_phase_offset_code};
			if (i_reg_wr && i_reg_addr == 8'h20) ctl_q <= i_reg_wdata[1:0];
			if (i_reg_wr && i_reg_addr == 8'h21) sel_q <= i_reg_wdata[0];
		end
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	// Pin toggles under low control, with pin source held two cycles
	sequence s_pin_switch;
		(ctl_q == 2'b00) && !$past(ctl_q[0]) &&
			$changed(i_external_ref_choice_pin);
	endsequence
	chk_offset_scale: assert property (o_phase_offset_ddeg ==
		(o_phase_offset_enable ? 9'(o_phase_offset_code) * 9'h009 : 9'h000))
		else $error("offset scale wrong");
	chk_pump_scale: assert property (o_second_pump_current_ua ==
		(13'(o_second_pump_current_code) + 13'h0001) * 13'h00C8)
		else $error("pump current wrong");
	chk_offset_write: assert property ((i_reg_wr && i_reg_addr == 8'h1D)
		|=> {o_phase_offset_enable, o_phase_offset_code} == wd_q[5:0])
		else $error("offset write lost");
	chk_offset_read: assert property ((i_reg_rd && i_reg_addr == 8'h1D)
		|=> o_reg_rdata == ofs_q) else $error("offset readback wrong");
	chk_mode_manual: assert property (o_manual_mode ==
		(!$past(ctl_q[1]) || !$past(o_selection_mode_field[0])))
		else $error("manual flag");
	chk_pin_select: assert property ((!i_reg_wr && !$past(i_reg_wr)
		&& o_manual_mode && !ctl_q[0])
		|=> o_active_ref == $past(i_external_ref_choice_pin))
		else $error("pin choice not followed");
	chk_int_select: assert property ((!i_reg_wr && !$past(i_reg_wr)
		&& o_manual_mode && ctl_q[0]) |=> o_active_ref == sel_q)
		else $error("select bit not followed");
	chk_hold_entry: assert property (s_pin_switch |=> o_holdover)
		else $error("no holdover on switch");
	chk_hold_none: assert property ((ctl_q[1] && !o_holdover)
		|=> !o_holdover) else $error("holdover entered");
	chk_gate_cause: assert property (o_ref_input_a_gated
		|-> $past(i_ref_input_a)) else $error("gated pulse without source");
endmodule
bind irs_input_ref_select_config irs_chk irs_chk_inst (.i_mclk, .i_sys_rst,
	.i_reg_addr, .i_reg_wr, .i_reg_wdata, .i_reg_rd,
	.i_external_ref_choice_pin, .i_ref_input_a, .o_reg_rdata,
	.o_phase_offset_enable, .o_phase_offset_code, .o_phase_offset_ddeg,
	.o_second_pump_current_code, .o_second_pump_current_ua,
	.o_ref_input_a_gated, .o_active_ref, .o_selection_mode_field,
	.o_holdover, .o_manual_mode);

// ---- bench/irs_ref_src.sv ----
// Two reference sources and an oscillator tick
`timescale 1ns/1ps
module irs_ref_src #(
	parameter int PER = 4
) (
	input  wire logic i_mclk,
	input  wire logic i_sys_rst,
	output logic      o_ref_a,
	output logic      o_ref_b,
	output logic      o_osc_tick
);
	int cnt;
	// Oscillator ticks each cycle; refs pulse once per PER, offset phases
	always_ff @(posedge i_mclk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			cnt        <= 0;
			o_ref_a    <= 1'b0;
			o_ref_b    <= 1'b0;
			o_osc_tick <= 1'b0;
		end else begin
			cnt        <= (cnt + 1) % PER;
			o_ref_a    <= (cnt == 0);
			o_ref_b    <= (cnt == PER / 2);
			o_osc_tick <= 1'b1;
		end
	end
endmodule

// ---- bench/input_ref_select_config_test.sv ----
// Self-checking bench for the reference selection configuration block
`timescale 1ns/1ps
module input_ref_select_config_test;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r;} irs_row_s;
	logic clk = 0, rst = 1, wr = 0, rd = 0, pin = 0, auto_c = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v;
	logic ra, rb, osc, ga, gb, act, hold, man, ofs_en;
	logic [4:0] ofs_c, cp_c;
	logic [8:0] ddeg;
	logic [12:0] ua;
	logic [5:0] ratio;
	logic [1:0] mode, pre, vc;
	logic [7:0] hp;
	int err_total = 0, tests_run = 0, cyc = 0, cnt_b = 0;
	irs_row_s rows[7] = '{'{8'h1D, 8'hFF, 8'h3F}, '{8'h1E, 8'hFF, 8'h1F},
		'{8'h20, 8'hFF, 8'hFF}, '{8'h21, 8'hFF, 8'h1D},
		'{8'h22, 8'h5A, 8'h5A}, '{8'h23, 8'hFF, 8'hC3},
		'{8'h30, 8'hFF, 8'h00}};
	logic [10:0] rat[9] = '{11'h001, 11'h044, 11'h090, 11'h0C8, 11'h402,
		11'h445, 11'h48C, 11'h4D8, 11'h520};
	always #12.5 clk = ~clk;
	irs_ref_src #(.PER(4)) irs_ref_src_inst (.i_mclk(clk), .i_sys_rst(rst),
		.o_ref_a(ra), .o_ref_b(rb), .o_osc_tick(osc));
	irs_input_ref_select_config irs_input_ref_select_config_inst (
		.i_mclk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
		.i_reg_wdata(wdata), .i_reg_rd(rd), .i_external_ref_choice_pin(pin),
		.i_auto_choice(auto_c), .i_ref_input_a(ra), .i_ref_input_b(rb),
		.i_osc_tick(osc), .o_reg_rdata(rdata), .o_phase_offset_enable(ofs_en),
		.o_phase_offset_code(ofs_c), .o_phase_offset_ddeg(ddeg),
		.o_second_pump_current_code(cp_c), .o_second_pump_current_ua(ua),
		.o_monitor_ratio(ratio), .o_ref_input_a_gated(ga),
		.o_ref_input_b_gated(gb), .o_active_ref(act),
		.o_selection_mode_field(mode), .o_holdover(hold),
		.o_manual_mode(man), .o_holdoff_period(hp),
		.o_holdoff_prescale(pre), .o_validation_count(vc));
	// Gated pulse counter and hang guard
	always @(posedge clk) begin
		cnt_b = cnt_b + int'(gb === 1'b1);
		cyc = cyc + 1;
		if (cyc == 6000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic check(input logic [12:0] s, input logic [12:0] e);
		tests_run++;
		if (s !== e) begin
			$display("BAD t=%0t seen %h want %h", $time, s, e);
			err_total++;
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		@(negedge clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		d = rdata;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic complete_run();
		if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		// Reset values
		check({ofs_en, ddeg}, 13'h0000);
		check(ua, 13'h0578);
		check(ratio, 13'h0001);
		check({mode, man, hold, hp}, 13'h0280);
		rd_reg(8'h20, v);
		check(v, 8'h02);
		// Write then read back each row
		foreach (rows[i]) begin
			wr_reg(rows[i].a, rows[i].d);
			rd_reg(rows[i].a, v);
			check(v, rows[i].r);
		end
		check({ofs_en, ddeg}, 13'h0317);
		check(ua, 13'h1900);
		check({pre, vc, hp}, 13'h0F5A);
		// Monitor ratio decode
		foreach (rat[i]) begin
			wr_reg(8'h20, {rat[i][10:6], 3'b010});
			check(ratio, rat[i][5:0]);
		end
		// Ratio matched to input rate, then mismatched
		wr_reg(8'h20, 8'h0A);
		wait_cyc(200);
		rd_reg(8'h24, v);
		check(v[1], 1'b1);
		wr_reg(8'h20, 8'h12);
		wait_cyc(600);
		rd_reg(8'h24, v);
		check(v[1], 1'b0);
		// Every mode code
		for (int m = 0; m < 4; m++) begin
			wr_reg(8'h21, {4'h0, 2'(m), 2'b00});
			wait_cyc(1);
			check({mode, man}, {2'(m), ~m[0]});
		end
		// Internal select, auto override, pin select
		wr_reg(8'h20, 8'h0B);
		wr_reg(8'h21, 8'h01);
		wait_cyc(2);
		check(act, 1'b1);
		wr_reg(8'h21, 8'h05);
		wait_cyc(2);
		check(act, 1'b0);
		wr_reg(8'h20, 8'h0A);
		wr_reg(8'h21, 8'h01);
		@(posedge clk) pin <= 1'b1;
		wait_cyc(2);
		check({act, hold}, 2'b10);
		// Manual switch with holdover control low
		wr_reg(8'h21, 8'h0C);
		wr_reg(8'h20, 8'h08);
		wait_cyc(1);
		check(man, 1'b1);
		@(posedge clk) pin <= 1'b0;
		wait_cyc(1);
		check({act, hold}, 2'b01);
		wr_reg(8'h20, 8'h0A);
		wait_cyc(2);
		check(hold, 1'b0);
		// Inactive input blocking on and off
		wr_reg(8'h20, 8'h0E);
		wait_cyc(1);
		cnt_b = 0;
		wait_cyc(40);
		check(cnt_b != 0, 1'b0);
		wr_reg(8'h20, 8'h0A);
		cnt_b = 0;
		wait_cyc(40);
		check(cnt_b != 0, 1'b1);
		complete_run();
	end
endmodule
